// ---- rtl/flash_protect_cfg.svh ----
`ifndef FLASH_PROTECT_CFG_SVH
`define FLASH_PROTECT_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FP_OFS_CTRL 8'h00
`define FP_OFS_CMD 8'h04
`define FP_OFS_ADDR 8'h08
`define FP_OFS_COUNT 8'h0c
`define FP_OFS_DATA 8'h10
`define FP_OFS_WINARG 8'h14
`define FP_OFS_FLAGS 8'h18
`define FP_OFS_STATUS 8'h1c
`define FP_OFS_IRQSTAT 8'h20
`define FP_OFS_IRQMASK 8'h24

// ----------------------------------------
// Geometry
// ----------------------------------------
`define FP_ADDR_W 18
`define FP_BLK_LSB 10
`define FP_NUM_BLOCKS 9'h100
`define FP_BOOT_BLOCKS 8'h04
`define FP_MAX_WORDS 7'h40

// ----------------------------------------
// Nonvolatile word fields (OK bits: 1 = permitted)
// ----------------------------------------
`define FP_F_ERASE_OK 0
`define FP_F_WRITE_OK 1
`define FP_F_BOOT_OK 2
`define FP_F_BOOT_FLAG 3
`define FP_F_WIN_START 8
`define FP_F_WIN_END 16
`define FP_CFG_RESET 32'h00ff000f

// ----------------------------------------
// Command opcodes
// ----------------------------------------
`define FP_OP_WRITE 4'h1
`define FP_OP_ERASE 4'h2
`define FP_OP_VERIFY 4'h3
`define FP_OP_SET_WIN 4'h4
`define FP_OP_INVERT 4'h5
`define FP_OP_SET_EP 4'h6
`define FP_OP_SET_WP 4'h7
`define FP_OP_SET_BP 4'h8
`define FP_OP_READ_FLAGS 4'h9

// ----------------------------------------
// Error codes
// ----------------------------------------
`define FP_ERR_NONE 4'h0
`define FP_ERR_BUSY 4'h1
`define FP_ERR_EPROT 4'h2
`define FP_ERR_WPROT 4'h3
`define FP_ERR_SHIELD 4'h4
`define FP_ERR_BPROT 4'h5
`define FP_ERR_PARAM 4'h6
`define FP_ERR_FAIL 4'h7
`define FP_ERR_INACTIVE 4'h8

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define FP_IRQ_DONE 0
`define FP_IRQ_ERR 1

`endif

// ---- rtl/flash_protect_pkg.sv ----
package flash_protect_pkg;

  typedef enum logic [2:0] {
    MOP_PROG,
    MOP_ERASE,
    MOP_VERIFY,
    MOP_CFGWR,
    MOP_CFGRD
  } mop_e;

  typedef enum logic [2:0] {
    ST_LOAD,
    ST_LOADW,
    ST_IDLE,
    ST_RUN
  } ctl_state_e;

  typedef enum logic [1:0] {
    SQ_IDLE,
    SQ_REQ,
    SQ_NEXT
  } seq_state_e;

endpackage

// ---- rtl/seq_if.sv ----
`timescale 1ns/1ps
interface seq_if;
  logic start;
  flash_protect_pkg::mop_e op;
  logic [17:0] addr;
  logic [6:0] count;
  logic [31:0] cfg;
  logic [5:0] bufIdx;
  logic [31:0] bufWord;
  logic done;
  logic fail;
  logic [31:0] rdata;

  modport ctl (output start, op, addr, count, cfg, bufWord,
    input bufIdx, done, fail, rdata);
  modport seq (input start, op, addr, count, cfg, bufWord,
    output bufIdx, done, fail, rdata);
endinterface

// ---- rtl/flash_seq.sv ----
`timescale 1ns/1ps
`include "flash_protect_cfg.svh"
module flash_seq (
  input wire logic core_clk,
  input wire logic reset_n,
  seq_if.seq sq,
  output logic flashReq,
  output flash_protect_pkg::mop_e flashOp,
  output logic [17:0] flashAddr,
  output logic [31:0] flashWdata,
  input wire logic flashAck,
  input wire logic flashFail,
  input wire logic [31:0] flashRdata
);

  flash_protect_pkg::seq_state_e state;
  logic [5:0] idx;
  logic [17:0] base;
  logic [6:0] count;

  assign sq.bufIdx = idx;

  // ----------------------------------------
  // Macro sequencing
  // ----------------------------------------
  // Programming walks the buffer one word per macro request; erase and
  // verify always address the block base so one request covers a block.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= flash_protect_pkg::SQ_IDLE;
      idx <= 6'h00;
      base <= 18'h00000;
      count <= 7'h00;
      flashReq <= 1'b0;
      flashOp <= flash_protect_pkg::MOP_CFGRD;
      flashAddr <= 18'h00000;
      flashWdata <= 32'h00000000;
      sq.done <= 1'b0;
      sq.fail <= 1'b0;
      sq.rdata <= 32'h00000000;
    end else begin
      sq.done <= 1'b0;
      case (state)
        flash_protect_pkg::SQ_IDLE: begin
          if (sq.start) begin
            flashReq <= 1'b1;
            flashOp <= sq.op;
            count <= sq.count;
            base <= sq.addr;
            flashWdata <= (sq.op == flash_protect_pkg::MOP_CFGWR) ?
              sq.cfg : sq.bufWord;
            if (sq.op == flash_protect_pkg::MOP_ERASE ||
                sq.op == flash_protect_pkg::MOP_VERIFY) begin
              flashAddr <= {sq.addr[17:10], 10'h000}; // see RULE11 RULE12
            end else begin
              flashAddr <= sq.addr;
            end
            state <= flash_protect_pkg::SQ_REQ;
          end
        end
        flash_protect_pkg::SQ_REQ: begin
          if (flashAck) begin
            flashReq <= 1'b0;
            if (!flashFail && flashOp == flash_protect_pkg::MOP_PROG &&
                ({1'b0, idx} + 7'h01) < count) begin
              idx <= idx + 6'h01; // see RULE10
              state <= flash_protect_pkg::SQ_NEXT;
            end else begin
              sq.done <= 1'b1;
              sq.fail <= flashFail;
              sq.rdata <= flashRdata;
              idx <= 6'h00;
              state <= flash_protect_pkg::SQ_IDLE;
            end
          end
        end
        flash_protect_pkg::SQ_NEXT: begin
          flashReq <= 1'b1;
          flashAddr <= base + {10'h000, idx, 2'b00};
          flashWdata <= sq.bufWord;
          state <= flash_protect_pkg::SQ_REQ;
        end
        default: begin
          state <= flash_protect_pkg::SQ_IDLE;
        end
      endcase
    end
  end

endmodule // flash_seq

// ---- rtl/flash_protect_boot_swap.sv ----
// Overview of operation
// RULE1: Refuse write/erase outside window while active
// RULE2: Window is inclusive start and end block
// RULE3: Erase protect only moves to protected
// RULE4: Write protect only moves to protected
// RULE5: Boot protect guards primary boot area
// RULE6: Boot ok reads 1; invert while 0 errors
// RULE7: Primary and alternate boot areas can swap
// RULE8: Inverted flag boots alternate after reset
// RULE9: Boot flag command toggles, never loads
// RULE10: Program 1 to 64 four-byte words
// RULE11: Erase clears one whole block
// RULE12: Verify checks one whole block
// RULE13: Swap code must not run from boot areas
// RULE14: Software checks boot ok before inverting
// RULE15: Flags live in nonvolatile storage
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "flash_protect_cfg.svh"
module flash_protect_boot_swap (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  output logic irq,
  output logic bootFromAlt,
  output logic flashReq,
  output flash_protect_pkg::mop_e flashOp,
  output logic [17:0] flashAddr,
  output logic [31:0] flashWdata,
  input wire logic flashAck,
  input wire logic flashFail,
  input wire logic [31:0] flashRdata
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  flash_protect_pkg::ctl_state_e state;
  logic selfProgActive;
  logic [17:0] addrReg;
  logic [6:0] countReg;
  logic [31:0] winArg;
  logic [31:0] irqStat;
  logic [31:0] irqMask;
  logic [31:0] nvCfg;
  logic [31:0] pendCfg;
  logic [31:0] wordBuf [0:63];
  logic [5:0] wrPtr;
  logic [3:0] lastErr;
  logic cfgRun;
  logic evDone;
  logic evErr;
  logic wrAcc;
  logic cmdWr;
  logic [3:0] cmdErr;
  logic cmdCfg;
  logic cmdNoop;
  flash_protect_pkg::mop_e cmdMop;
  logic [31:0] next_cfg;
  logic [7:0] firstBlk;
  logic [7:0] lastBlk;
  logic [17:0] endAddr;

  seq_if sq ();

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] blockOf(input logic [17:0] a);
    return a[17:10];
  endfunction

  function automatic logic inWindow(input logic [7:0] b,
                                    input logic [31:0] c);
    return (b >= c[15:8]) && (b <= c[23:16]); // see RULE2
  endfunction

  function automatic logic inBoot(input logic [7:0] b);
    return b < `FP_BOOT_BLOCKS;
  endfunction

  function automatic logic [31:0] mergeBe(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign wrAcc = avsWrite & ~avsWaitrequest;
  assign cmdWr = wrAcc && avsAddress == `FP_OFS_CMD && avsByteenable[0];

  // ----------------------------------------
  // Bus handshake and read data
  // ----------------------------------------
  // One wait cycle per access keeps read data a plain register.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      avsWaitrequest <= 1'b1;
      avsReaddata <= 32'h00000000;
    end else begin
      avsWaitrequest <= ~((avsRead | avsWrite) & avsWaitrequest);
      if (avsRead && avsWaitrequest) begin
        case (avsAddress)
          `FP_OFS_CTRL: avsReaddata <= {31'h0, selfProgActive};
          `FP_OFS_ADDR: avsReaddata <= {14'h0, addrReg};
          `FP_OFS_COUNT: avsReaddata <= {25'h0, countReg};
          `FP_OFS_WINARG: avsReaddata <= winArg;
          `FP_OFS_FLAGS: avsReaddata <= nvCfg; // see RULE6
          `FP_OFS_STATUS: avsReaddata <= {18'h0, wrPtr, lastErr,
            2'b00, bootFromAlt, state != flash_protect_pkg::ST_IDLE};
          `FP_OFS_IRQSTAT: avsReaddata <= irqStat;
          `FP_OFS_IRQMASK: avsReaddata <= irqMask;
          default: avsReaddata <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Software settings
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      selfProgActive <= 1'b0;
      addrReg <= 18'h00000;
      countReg <= 7'h00;
      winArg <= 32'h00000000;
      irqMask <= 32'h00000000;
    end else if (wrAcc) begin
      case (avsAddress)
        `FP_OFS_CTRL: begin
          if (avsByteenable[0]) begin
            selfProgActive <= avsWritedata[0];
          end
        end
        `FP_OFS_ADDR: addrReg <=
          18'(mergeBe({14'h0, addrReg}, avsWritedata, avsByteenable));
        `FP_OFS_COUNT: begin
          if (avsByteenable[0]) begin
            countReg <= avsWritedata[6:0];
          end
        end
        `FP_OFS_WINARG: winArg <= mergeBe(winArg, avsWritedata,
          avsByteenable);
        `FP_OFS_IRQMASK: irqMask <= mergeBe(irqMask, avsWritedata,
          avsByteenable) & 32'h00000003;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Program data buffer
  // ----------------------------------------
  // Pointer rewinds once a command is accepted, so a new burst of data
  // always lands at word zero.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wrPtr <= 6'h00;
    end else if (wrAcc && avsAddress == `FP_OFS_DATA) begin
      wordBuf[wrPtr] <= avsWritedata; // see RULE10
      wrPtr <= wrPtr + 6'h01;
    end else if (cmdWr && state == flash_protect_pkg::ST_IDLE) begin
      wrPtr <= 6'h00;
    end
  end

  assign sq.bufWord = wordBuf[sq.bufIdx];

  // ----------------------------------------
  // Command checking
  // ----------------------------------------
  assign endAddr = addrReg + {9'h000, countReg - 7'h01, 2'b00};
  assign firstBlk = blockOf(addrReg);
  assign lastBlk = blockOf(endAddr);

  always_comb begin
    cmdErr = `FP_ERR_NONE;
    cmdCfg = 1'b0;
    cmdNoop = 1'b0;
    cmdMop = flash_protect_pkg::MOP_PROG;
    next_cfg = nvCfg;
    case (avsWritedata[3:0])
      `FP_OP_WRITE: begin
        if (countReg == 7'h00 || countReg > `FP_MAX_WORDS) begin
          cmdErr = `FP_ERR_PARAM; // see RULE10
        end else if (!nvCfg[`FP_F_WRITE_OK]) begin
          cmdErr = `FP_ERR_WPROT; // see RULE4
        end else if (!inWindow(firstBlk, nvCfg) ||
                     !inWindow(lastBlk, nvCfg)) begin
          cmdErr = `FP_ERR_SHIELD; // see RULE1
        end else if (!nvCfg[`FP_F_BOOT_OK] &&
                     (inBoot(firstBlk) || inBoot(lastBlk))) begin
          cmdErr = `FP_ERR_BPROT; // see RULE5
        end
      end
      `FP_OP_ERASE: begin
        cmdMop = flash_protect_pkg::MOP_ERASE;
        if (!nvCfg[`FP_F_ERASE_OK]) begin
          cmdErr = `FP_ERR_EPROT; // see RULE3
        end else if (!inWindow(firstBlk, nvCfg)) begin
          cmdErr = `FP_ERR_SHIELD; // see RULE1
        end else if (!nvCfg[`FP_F_BOOT_OK] && inBoot(firstBlk)) begin
          cmdErr = `FP_ERR_BPROT; // see RULE5
        end
      end
      `FP_OP_VERIFY: begin
        cmdMop = flash_protect_pkg::MOP_VERIFY; // see RULE12
      end
      `FP_OP_SET_WIN: begin
        cmdCfg = 1'b1;
        if (winArg[7:0] > winArg[15:8]) begin
          cmdErr = `FP_ERR_PARAM;
        end
        next_cfg[`FP_F_WIN_START +: 8] = winArg[7:0]; // see RULE2
        next_cfg[`FP_F_WIN_END +: 8] = winArg[15:8];
      end
      `FP_OP_INVERT: begin
        cmdCfg = 1'b1;
        if (!nvCfg[`FP_F_BOOT_OK]) begin
          cmdErr = `FP_ERR_BPROT; // see RULE6
        end
        next_cfg[`FP_F_BOOT_FLAG] = ~nvCfg[`FP_F_BOOT_FLAG]; // see RULE9
      end
      `FP_OP_SET_EP: begin
        cmdCfg = 1'b1;
        next_cfg[`FP_F_ERASE_OK] = 1'b0; // see RULE3
      end
      `FP_OP_SET_WP: begin
        cmdCfg = 1'b1;
        next_cfg[`FP_F_WRITE_OK] = 1'b0; // see RULE4
      end
      `FP_OP_SET_BP: begin
        cmdCfg = 1'b1;
        next_cfg[`FP_F_BOOT_OK] = 1'b0; // see RULE5
      end
      `FP_OP_READ_FLAGS: begin
        cmdNoop = 1'b1;
      end
      default: begin
        cmdErr = `FP_ERR_PARAM;
      end
    endcase
    if (!selfProgActive && !cmdNoop) begin
      cmdErr = `FP_ERR_INACTIVE;
    end
  end

  // ----------------------------------------
  // Control sequence
  // ----------------------------------------
  // Flags are only committed after the nonvolatile write succeeds, so a
  // failed write leaves the previous protection in force.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= flash_protect_pkg::ST_LOAD;
      nvCfg <= `FP_CFG_RESET;
      pendCfg <= `FP_CFG_RESET;
      lastErr <= `FP_ERR_NONE;
      cfgRun <= 1'b0;
      bootFromAlt <= 1'b0;
      evDone <= 1'b0;
      evErr <= 1'b0;
      sq.start <= 1'b0;
      sq.op <= flash_protect_pkg::MOP_CFGRD;
      sq.addr <= 18'h00000;
      sq.count <= 7'h00;
      sq.cfg <= 32'h00000000;
    end else begin
      sq.start <= 1'b0;
      evDone <= 1'b0;
      evErr <= 1'b0;
      case (state)
        flash_protect_pkg::ST_LOAD: begin
          sq.start <= 1'b1;
          sq.op <= flash_protect_pkg::MOP_CFGRD; // see RULE15
          state <= flash_protect_pkg::ST_LOADW;
        end
        flash_protect_pkg::ST_LOADW: begin
          if (sq.done) begin
            nvCfg <= sq.rdata;
            bootFromAlt <= ~sq.rdata[`FP_F_BOOT_FLAG]; // see RULE7 RULE8
            state <= flash_protect_pkg::ST_IDLE;
          end
        end
        flash_protect_pkg::ST_IDLE: begin
          if (cmdWr) begin
            if (cmdErr != `FP_ERR_NONE) begin
              lastErr <= cmdErr;
              evErr <= 1'b1;
              evDone <= 1'b1;
            end else if (cmdNoop) begin
              lastErr <= `FP_ERR_NONE;
              evDone <= 1'b1;
            end else begin
              lastErr <= `FP_ERR_NONE;
              sq.start <= 1'b1;
              sq.addr <= addrReg;
              sq.count <= countReg;
              cfgRun <= cmdCfg;
              pendCfg <= next_cfg;
              sq.cfg <= next_cfg;
              sq.op <= cmdCfg ? flash_protect_pkg::MOP_CFGWR : cmdMop;
              state <= flash_protect_pkg::ST_RUN;
            end
          end
        end
        flash_protect_pkg::ST_RUN: begin
          if (sq.done) begin
            evDone <= 1'b1;
            if (sq.fail) begin
              lastErr <= `FP_ERR_FAIL;
              evErr <= 1'b1;
            end else if (cfgRun) begin
              nvCfg <= pendCfg; // see RULE15
            end
            state <= flash_protect_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= flash_protect_pkg::ST_IDLE;
        end
      endcase
      if (cmdWr && state != flash_protect_pkg::ST_IDLE) begin
        lastErr <= `FP_ERR_BUSY;
        evErr <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  // A set in the same cycle as a write-one-to-clear wins.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irqStat <= 32'h00000000;
      irq <= 1'b0;
    end else begin
      if (wrAcc && avsAddress == `FP_OFS_IRQSTAT && avsByteenable[0]) begin
        irqStat <= (irqStat & ~avsWritedata & 32'h00000003) |
          {30'h0, evErr, evDone};
      end else begin
        irqStat <= irqStat | {30'h0, evErr, evDone};
      end
      irq <= |(irqStat & irqMask);
    end
  end

  // ----------------------------------------
  // Flash macro sequencer
  // ----------------------------------------
  flash_seq u_seq (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .sq(sq.seq),
    .flashReq(flashReq),
    .flashOp(flashOp),
    .flashAddr(flashAddr),
    .flashWdata(flashWdata),
    .flashAck(flashAck),
    .flashFail(flashFail),
    .flashRdata(flashRdata)
  );

endmodule // flash_protect_boot_swap

// ---- bench/flash_protect_boot_swap_chk.sv ----
`timescale 1ns/1ps
module flash_protect_boot_swap_chk (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic avsWaitrequest,
  input wire logic bootFromAlt,
  input wire logic flashReq,
  input flash_protect_pkg::mop_e flashOp,
  input wire logic [17:0] flashAddr,
  input wire logic flashAck,
  input wire logic [31:0] flashRdata
);
  // ----------------------------------------
  // Bus, flash handshake and boot properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_req;
    (avsRead || avsWrite) && avsWaitrequest;
  endsequence
  sequence s_cfg_ack;
    flashReq && flashAck && flashOp == flash_protect_pkg::MOP_CFGRD;
  endsequence
  property p_bus_answer;
    s_req |=> !avsWaitrequest ##1 avsWaitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not one cycle late and long");
  property p_req_hold;
    flashReq && !flashAck |=> flashReq && $stable(flashAddr);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("flash request moved before ack");
  property p_req_drop;
    flashReq && flashAck |=> !flashReq;
  endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("flash request kept after ack");
  property p_block_base;
    flashReq && (flashOp == flash_protect_pkg::MOP_ERASE ||
      flashOp == flash_protect_pkg::MOP_VERIFY) |-> flashAddr[9:0] == 10'h0;
  endproperty
  a_block_base: assert property (p_block_base)
    else $error("block operation off block base");
  property p_word_align;
    flashReq && flashOp == flash_protect_pkg::MOP_PROG |-> !(|flashAddr[1:0]);
  endproperty
  a_word_align: assert property (p_word_align)
    else $error("program address not word aligned");
  // Boot source follows the stored flag only at the reload after reset
  property p_boot_load;
    s_cfg_ack |=> ##1 bootFromAlt == !$past(flashRdata[3], 2);
  endproperty
  a_boot_load: assert property (p_boot_load)
    else $error("boot source differs from stored flag");
  property p_boot_hold;
    !((flashAck || $past(flashAck)) &&
      flashOp == flash_protect_pkg::MOP_CFGRD) |=> $stable(bootFromAlt);
  endproperty
  a_boot_hold: assert property (p_boot_hold)
    else $error("boot source changed without reload");
  property p_load_start;
    $rose(reset_n) |-> ##[1:4] flashReq &&
      flashOp == flash_protect_pkg::MOP_CFGRD;
  endproperty
  a_load_start: assert property (p_load_start)
    else $error("stored flags not fetched after reset");
endmodule // flash_protect_boot_swap_chk

bind flash_protect_boot_swap flash_protect_boot_swap_chk chk (
  .core_clk(core_clk), .reset_n(reset_n), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsWaitrequest(avsWaitrequest),
  .bootFromAlt(bootFromAlt), .flashReq(flashReq), .flashOp(flashOp),
  .flashAddr(flashAddr), .flashAck(flashAck), .flashRdata(flashRdata));

// ---- bench/flash_macro_model.sv ----
`timescale 1ns/1ps
`include "flash_protect_cfg.svh"
module flash_macro_model (
  input wire logic core_clk,
  input wire logic flashReq,
  input flash_protect_pkg::mop_e flashOp,
  input wire logic [17:0] flashAddr,
  input wire logic [31:0] flashWdata,
  input wire logic failNext,
  input wire logic [1:0] ackDelay,
  output logic flashAck = 1'b0,
  output logic flashFail = 1'b0,
  output logic [31:0] flashRdata = 32'h0,
  output logic [31:0] progCount = 32'h0,
  output logic [17:0] lastAddr = 18'h0,
  output logic [31:0] lastData = 32'h0
);
  // ----------------------------------------
  // Flash macro with its configuration word
  // ----------------------------------------
  // Never cleared: it stands for cells that outlive reset and power loss
  logic [31:0] nvWord = `FP_CFG_RESET;
  logic [1:0] waitCnt = 2'h0;
  // Fail and read data wander while idle so stale values never pass
  always @(posedge core_clk) begin
    flashAck <= 1'b0;
    flashFail <= ~flashFail;
    flashRdata <= ~flashRdata;
    if (flashReq && !flashAck) begin
      waitCnt <= waitCnt + 2'h1;
      if (waitCnt >= ackDelay) begin
        waitCnt <= 2'h0;
        flashAck <= 1'b1;
        flashFail <= failNext;
        if (flashOp == flash_protect_pkg::MOP_CFGRD)
          flashRdata <= nvWord;
        if (flashOp == flash_protect_pkg::MOP_CFGWR && !failNext)
          nvWord <= flashWdata;
        if (flashOp == flash_protect_pkg::MOP_PROG)
          progCount <= progCount + 32'h1;
        if (flashOp < flash_protect_pkg::MOP_CFGWR) begin
          lastAddr <= flashAddr;
          lastData <= flashWdata;
        end
      end
    end
  end
endmodule // flash_macro_model

// ---- bench/flash_protect_boot_swap_bench.sv ----
`timescale 1ns/1ps
module flash_protect_boot_swap_bench;
  logic coreClk = 1'b0;
  logic resetN = 1'b0;
  logic [7:0] avsAddress = 8'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic failNext = 1'b0;
  logic [1:0] ackDelay = 2'h0;
  logic avsWaitrequest, irq, bootFromAlt, flashReq, flashAck, flashFail;
  flash_protect_pkg::mop_e flashOp;
  logic [17:0] flashAddr, lastAddr;
  logic [31:0] avsReaddata, flashWdata, flashRdata, progCount, lastData, r;
  int numErrors = 0;
  int checkCount = 0;
  int cycles = 0;

  always #2.5 coreClk = ~coreClk;

  flash_protect_boot_swap uut (
    .core_clk(coreClk), .reset_n(resetN), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
    .avsByteenable(4'hf), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .irq(irq), .bootFromAlt(bootFromAlt),
    .flashReq(flashReq), .flashOp(flashOp), .flashAddr(flashAddr),
    .flashWdata(flashWdata), .flashAck(flashAck), .flashFail(flashFail),
    .flashRdata(flashRdata));
  flash_macro_model mac (
    .core_clk(coreClk), .flashReq(flashReq), .flashOp(flashOp),
    .flashAddr(flashAddr), .flashWdata(flashWdata), .failNext(failNext),
    .ackDelay(ackDelay), .flashAck(flashAck), .flashFail(flashFail),
    .flashRdata(flashRdata), .progCount(progCount), .lastAddr(lastAddr),
    .lastData(lastData));

  // ----------------------------------------
  // Bus tasks and checks
  // ----------------------------------------
  task automatic completeRun;
    $display("checks %0d errors %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Requests are held until waitrequest is seen low, then an edge passes
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= 1'b1;
    @(posedge coreClk);
    while (avsWaitrequest !== 1'b0) @(posedge coreClk);
    avsWrite <= 1'b0;
    @(posedge coreClk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    avsAddress <= a;
    avsRead <= 1'b1;
    @(posedge coreClk);
    while (avsWaitrequest !== 1'b0) @(posedge coreClk);
    d = avsReaddata;
    avsRead <= 1'b0;
    @(posedge coreClk);
  endtask
  task automatic rchk(input string what, input logic [7:0] a,
      input logic [31:0] e);
    rd(a, r);
    check(what, e, r);
  endtask
  // Command with address and count; waits for done or error, then clears
  task automatic op(input logic [17:0] a, input logic [6:0] n,
      input logic [3:0] c, input logic [3:0] e);
    wr(8'h08, {14'h0, a});
    wr(8'h0c, {25'h0, n});
    wr(8'h04, {28'h0, c});
    r = 32'h0;
    while (r[1:0] == 2'b00) rd(8'h20, r);
    check("error flag", {31'h0, e != 4'h0}, {31'h0, r[1]});
    rd(8'h1c, r);
    check("last error", {28'h0, e}, {28'h0, r[7:4]});
    wr(8'h20, 32'h3);
  endtask
  task automatic resetDut;
    resetN <= 1'b0;
    repeat (10) @(posedge coreClk);
    resetN <= 1'b1;
    while (flashReq !== 1'b1) @(posedge coreClk);
    while (flashReq !== 1'b0) @(posedge coreClk);
    @(posedge coreClk);
  endtask

  always @(posedge coreClk) begin
    cycles++;
    if (cycles == 20000) begin
      numErrors++;
      completeRun();
    end
  end

  initial begin
    resetDut();
    rchk("flags", 8'h18, 32'h00ff000f);
    rchk("ctrl", 8'h00, 32'h0);
    rchk("unmapped", 8'h3c, 32'h0);
    op(18'h0, 7'h1, 4'h1, 4'h8);
    wr(8'h04, 32'h9);
    rd(8'h20, r);
    rd(8'h20, r);
    check("irq status", 32'h1, r);
    check("irq masked", 32'h0, {31'h0, irq});
    wr(8'h24, 32'h3);
    rd(8'h20, r);
    check("irq", 32'h1, {31'h0, irq});
    wr(8'h20, 32'h1);
    rd(8'h20, r);
    check("irq cleared", 32'h0, {31'h0, irq});
    wr(8'h00, 32'h1);
    wr(8'h14, 32'h0209);
    op(18'h0, 7'h0, 4'h4, 4'h6);
    wr(8'h14, 32'h0908);
    op(18'h0, 7'h0, 4'h4, 4'h0);
    rchk("window", 8'h18, 32'h0009080f);
    for (int i = 0; i < 64; i++) wr(8'h10, 32'ha5000000 + i);
    ackDelay <= 2'h3;
    wr(8'h08, 32'h2000);
    wr(8'h0c, 32'h40);
    wr(8'h04, 32'h1);
    op(18'h2000, 7'h40, 4'h1, 4'h1);
    r = 32'h0;
    while (r[0] !== 1'b1) rd(8'h20, r);
    wr(8'h20, 32'h3);
    check("words", 32'd64, progCount);
    check("last addr", 32'h20fc, {14'h0, lastAddr});
    check("last data", 32'ha500003f, lastData);
    ackDelay <= 2'h0;
    wr(8'h10, 32'h1234abcd);
    op(18'h27fc, 7'h1, 4'h1, 4'h0);
    check("edge addr", 32'h27fc, {14'h0, lastAddr});
    op(18'h27f8, 7'h4, 4'h1, 4'h4);
    op(18'h1ffc, 7'h1, 4'h1, 4'h4);
    op(18'h2000, 7'h0, 4'h1, 4'h6);
    op(18'h2000, 7'h41, 4'h1, 4'h6);
    check("words", 32'd65, progCount);
    op(18'h2404, 7'h0, 4'h2, 4'h0);
    check("erase addr", 32'h2400, {14'h0, lastAddr});
    op(18'h2800, 7'h0, 4'h2, 4'h4);
    op(18'h2bfc, 7'h0, 4'h3, 4'h0);
    check("verify addr", 32'h2800, {14'h0, lastAddr});
    failNext <= 1'b1;
    op(18'h2400, 7'h0, 4'h2, 4'h7);
    failNext <= 1'b0;
    rchk("boot ok", 8'h18, 32'h0009080f);
    op(18'h0, 7'h0, 4'h5, 4'h0);
    rchk("flag", 8'h18, 32'h00090807);
    rchk("status", 8'h1c, 32'h0);
    resetDut();
    check("alt boot", 32'h1, {31'h0, bootFromAlt});
    rchk("kept", 8'h18, 32'h00090807);
    rchk("status", 8'h1c, 32'h2);
    wr(8'h00, 32'h1);
    op(18'h0, 7'h0, 4'h5, 4'h0);
    resetDut();
    check("primary", 32'h0, {31'h0, bootFromAlt});
    wr(8'h00, 32'h1);
    op(18'h0, 7'h0, 4'h8, 4'h0);
    rchk("boot ok", 8'h18, 32'h0009080b);
    op(18'h0, 7'h0, 4'h5, 4'h5);
    op(18'h0, 7'h0, 4'h6, 4'h0);
    op(18'h2400, 7'h0, 4'h2, 4'h2);
    op(18'h0, 7'h0, 4'h7, 4'h0);
    op(18'h2400, 7'h1, 4'h1, 4'h3);
    resetDut();
    rchk("protected", 8'h18, 32'h00090808);
    completeRun();
  end
endmodule // flash_protect_boot_swap_bench
